/* verilog/clkgen_pkg.sv */
// constants for the clock generator control block
package clkgen_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] OFF_CTRL_ONE = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_CTRL_TWO = 4'h1;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h2;
   localparam logic [DATA_W-1:0] CTRL_ONE_RST = 8'h04;
   localparam logic [DATA_W-1:0] CTRL_TWO_RST = 8'h40;
   localparam int SRC_HI = 7;
   localparam int SRC_LO = 6;
   localparam int EXT_REF_DIVIDER_HI = 5;
   localparam int EXT_REF_DIVIDER_LO = 3;
   localparam int REF_SELECT_INTERNAL_B = 2;
   localparam int INT_REF_OUT_ENABLE_B = 1;
   localparam int IRSTOP_B = 0;
   localparam int BUS_CLOCK_DIVIDER_HI = 7;
   localparam int BUS_CLOCK_DIVIDER_LO = 6;
   localparam int RANGE_B = 5;
   localparam int HGO_B = 4;
   localparam int LP_B = 3;
   localparam int EXT_SOURCE_OSC_SELECT_B = 2;
   localparam int EXT_REF_OUT_ENABLE_B = 1;
   localparam int ERSTOP_B = 0;
   localparam logic [1:0] SRC_LOOP = 2'h0;
   localparam logic [1:0] SRC_INT = 2'h1;
   localparam logic [1:0] SRC_EXT = 2'h2;
   localparam logic [1:0] SRC_RSVD = 2'h3;
   localparam logic [2:0] EXT_REF_DIVIDER_MAX_EXTRA_DIV_BY_32 = 3'h5;
   localparam int EXTRA_DIV_BY_32_SHIFT = 5;
   localparam int DIV_W = 11;
   localparam int BUS_DIV_W = 4;
   localparam int CNT_W = 11;
endpackage

/* verilog/clk_divider.sv */
// divide-by-n enable pulse generator
`timescale 1ns/1ps
module clk_divider (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick_in,
   input wire logic [clkgen_pkg::CNT_W-1:0] divisor,
   output logic tick_out
);
   logic [clkgen_pkg::CNT_W-1:0] cnt_r;
   logic [clkgen_pkg::CNT_W-1:0] cnt_nxt;
   logic wrap;
   assign wrap = (cnt_r + clkgen_pkg::CNT_W'(1)) >= divisor;
   assign cnt_nxt = !tick_in ? cnt_r : (wrap ? '0 : cnt_r + clkgen_pkg::CNT_W'(1));
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         tick_out <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick_out <= tick_in && wrap;
      end
   end
endmodule

/* verilog/clock_generator_control_regs.sv */
// clock generator control registers, source select and dividers
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
//
// Behaviour
// - source select: 00 loop, 01 internal, 10 external
// - reserved source code 11 acts as 00
// - fll low range: divide by 2^code
// - fll high range extra_div_by_32: 32..1024, 6-7 reserved
// - pll external reference: divide by 2^code
// - ref select bit: 1 internal, 0 external
// - internal reference output enable bit
// - internal reference kept in stop conditionally
// - bus divider 1/2/4/8, resets to 2
// - range bit: 1 high, 0 low
// - gain bit: 1 high gain, 0 low power
// - low power bit disables loop when bypassed
// - external source: 1 oscillator, 0 clock
// - external reference output enable bit
// - external reference kept in stop conditionally
module clock_generator_control_regs (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [clkgen_pkg::ADDR_W-1:0] addr,
   input wire logic [clkgen_pkg::DATA_W-1:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic stop_req,
   input wire logic pll_select,
   input wire logic int_ref_tick,
   input wire logic ext_ref_tick,
   input wire logic loop_tick,
   output logic [clkgen_pkg::DATA_W-1:0] rdata,
   output logic [1:0] sys_src_active,
   output logic sys_clk_tick,
   output logic bus_clk_tick,
   output logic ext_ref_div_tick,
   output logic int_ref_clock_out,
   output logic ext_ref_clock_out,
   output logic int_ref_enable,
   output logic ext_ref_enable,
   output logic loop_enable,
   output logic osc_high_range,
   output logic osc_high_gain,
   output logic ext_source_osc_select,
   output logic div_reserved
);
   typedef enum logic [2:0] {
      ST_LOOP_ENGAGED = 3'h0,
      ST_LOOP_BYPASSED = 3'h1,
      ST_LOW_POWER = 3'h3,
      ST_STOP = 3'h2,
      ST_SPARE = 3'h6
   } mode_t;

   logic [clkgen_pkg::DATA_W-1:0] clock_control_one_r;
   logic [clkgen_pkg::DATA_W-1:0] clock_control_two_r;
   logic stop_s1_r;
   logic stop_s2_r;
   mode_t mode_r;
   mode_t mode_nxt;
   logic prior_int_r;
   logic prior_ext_r;

   function automatic logic [clkgen_pkg::CNT_W-1:0] pow2(input logic [2:0] code);
      pow2 = clkgen_pkg::CNT_W'(1) << code;
   endfunction

   // register fields
   wire [1:0] sys_clk_source_sel =
      clock_control_one_r[clkgen_pkg::SRC_HI:clkgen_pkg::SRC_LO];
   wire [2:0] ext_ref_divider =
      clock_control_one_r[clkgen_pkg::EXT_REF_DIVIDER_HI:clkgen_pkg::EXT_REF_DIVIDER_LO];
   wire ref_select_internal = clock_control_one_r[clkgen_pkg::REF_SELECT_INTERNAL_B];
   wire int_ref_out_enable = clock_control_one_r[clkgen_pkg::INT_REF_OUT_ENABLE_B];
   wire int_ref_stop_keep = clock_control_one_r[clkgen_pkg::IRSTOP_B];
   wire [1:0] bus_clock_divider =
      clock_control_two_r[clkgen_pkg::BUS_CLOCK_DIVIDER_HI:clkgen_pkg::BUS_CLOCK_DIVIDER_LO];
   wire range_high = clock_control_two_r[clkgen_pkg::RANGE_B];
   wire gain_high = clock_control_two_r[clkgen_pkg::HGO_B];
   wire bypass_low_power = clock_control_two_r[clkgen_pkg::LP_B];
   wire ext_osc_sel = clock_control_two_r[clkgen_pkg::EXT_SOURCE_OSC_SELECT_B];
   wire ext_ref_out_enable = clock_control_two_r[clkgen_pkg::EXT_REF_OUT_ENABLE_B];
   wire ext_ref_stop_keep = clock_control_two_r[clkgen_pkg::ERSTOP_B];

   // effective source, reserved code folded onto loop
   wire [1:0] src_eff = (sys_clk_source_sel == clkgen_pkg::SRC_RSVD) ?
      clkgen_pkg::SRC_LOOP : sys_clk_source_sel;
   wire src_bypassed = src_eff != clkgen_pkg::SRC_LOOP;
   wire in_stop = stop_s2_r;

   // reference divider selection
   wire extra_div_by_32_mode = range_high && !pll_select;
   wire ext_ref_divider_reserved = extra_div_by_32_mode && (ext_ref_divider > clkgen_pkg::EXT_REF_DIVIDER_MAX_EXTRA_DIV_BY_32);
   wire [clkgen_pkg::CNT_W-1:0] ext_ref_divider_factor = extra_div_by_32_mode ?
      (pow2(ext_ref_divider) << clkgen_pkg::EXTRA_DIV_BY_32_SHIFT) : pow2(ext_ref_divider);
   wire [clkgen_pkg::CNT_W-1:0] bus_clock_divider_factor = pow2({1'b0, bus_clock_divider});

   // which references the current mode consumes
   wire mode_uses_int = ref_select_internal || src_eff == clkgen_pkg::SRC_INT;
   wire mode_uses_ext = (!ref_select_internal && src_eff != clkgen_pkg::SRC_INT) ||
      src_eff == clkgen_pkg::SRC_EXT;

   // reference enables, stop handling
   wire int_en_nxt = in_stop ? (int_ref_stop_keep && (int_ref_out_enable || prior_int_r)) :
      (int_ref_out_enable || mode_uses_int);
   wire ext_en_nxt = in_stop ? (ext_ref_stop_keep && (ext_ref_out_enable || prior_ext_r)) :
      (ext_ref_out_enable || mode_uses_ext);
   wire loop_en_nxt = (mode_nxt == ST_LOOP_ENGAGED) || (mode_nxt == ST_LOOP_BYPASSED);

   // selected source tick
   wire src_tick = (src_eff == clkgen_pkg::SRC_INT) ? int_ref_tick :
      (src_eff == clkgen_pkg::SRC_EXT) ? ext_ref_tick : loop_tick;

   // read mux
   wire [clkgen_pkg::DATA_W-1:0] status_word = {2'h0, ext_ref_divider_reserved, loop_enable,
      ext_ref_enable, int_ref_enable, src_eff};
   wire [clkgen_pkg::DATA_W-1:0] rd_mux =
      (addr == clkgen_pkg::OFF_CTRL_ONE) ? clock_control_one_r :
      (addr == clkgen_pkg::OFF_CTRL_TWO) ? clock_control_two_r :
      (addr == clkgen_pkg::OFF_STATUS) ? status_word : '0;

   always_comb begin
      case (mode_r)
         ST_STOP: begin
            mode_nxt = in_stop ? ST_STOP : ST_LOOP_ENGAGED;
         end
         ST_LOOP_ENGAGED, ST_LOOP_BYPASSED, ST_LOW_POWER: begin
            if (in_stop) begin
               mode_nxt = ST_STOP;
            end else if (!src_bypassed) begin
               mode_nxt = ST_LOOP_ENGAGED;
            end else if (bypass_low_power) begin
               mode_nxt = ST_LOW_POWER;
            end else begin
               mode_nxt = ST_LOOP_BYPASSED;
            end
         end
         default: begin
            mode_nxt = ST_LOOP_ENGAGED;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clock_control_one_r <= clkgen_pkg::CTRL_ONE_RST;
         clock_control_two_r <= clkgen_pkg::CTRL_TWO_RST;
      end else if (wr_en) begin
         if (addr == clkgen_pkg::OFF_CTRL_ONE) begin
            clock_control_one_r <= wdata;
         end
         if (addr == clkgen_pkg::OFF_CTRL_TWO) begin
            clock_control_two_r <= wdata;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stop_s1_r <= 1'b0;
         stop_s2_r <= 1'b0;
         mode_r <= ST_LOOP_ENGAGED;
         prior_int_r <= 1'b0;
         prior_ext_r <= 1'b0;
      end else begin
         stop_s1_r <= stop_req;
         stop_s2_r <= stop_s1_r;
         mode_r <= mode_nxt;
         if (!in_stop) begin
            prior_int_r <= mode_uses_int;
            prior_ext_r <= mode_uses_ext;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
         sys_src_active <= clkgen_pkg::SRC_LOOP;
         sys_clk_tick <= 1'b0;
         int_ref_clock_out <= 1'b0;
         ext_ref_clock_out <= 1'b0;
         int_ref_enable <= 1'b0;
         ext_ref_enable <= 1'b0;
         loop_enable <= 1'b1;
         osc_high_range <= 1'b0;
         osc_high_gain <= 1'b0;
         ext_source_osc_select <= 1'b0;
         div_reserved <= 1'b0;
      end else begin
         rdata <= rd_en ? rd_mux : '0;
         sys_src_active <= src_eff;
         sys_clk_tick <= src_tick && !in_stop;
         int_ref_clock_out <= int_ref_out_enable && int_en_nxt && int_ref_tick;
         ext_ref_clock_out <= ext_ref_out_enable && ext_en_nxt && ext_ref_tick;
         int_ref_enable <= int_en_nxt;
         ext_ref_enable <= ext_en_nxt;
         loop_enable <= loop_en_nxt;
         osc_high_range <= range_high;
         osc_high_gain <= gain_high;
         ext_source_osc_select <= ext_osc_sel;
         div_reserved <= ext_ref_divider_reserved;
      end
   end

   clk_divider u_bus_div (
      .clk(clk),
      .rst_n(rst_n),
      .tick_in(sys_clk_tick),
      .divisor(bus_clock_divider_factor),
      .tick_out(bus_clk_tick)
   );

   // reserved codes hold the divider stopped
   clk_divider u_ref_div (
      .clk(clk),
      .rst_n(rst_n),
      .tick_in(ext_ref_tick && !ext_ref_divider_reserved),
      .divisor(ext_ref_divider_factor),
      .tick_out(ext_ref_div_tick)
   );

   AST_RSVD_SRC: assert property (@(posedge clk) disable iff (!rst_n)
      sys_clk_source_sel == clkgen_pkg::SRC_RSVD |=> sys_src_active == clkgen_pkg::SRC_LOOP)
      else $error("reserved source not mapped to loop");
   AST_SRC_MAP: assert property (@(posedge clk) disable iff (!rst_n)
      sys_clk_source_sel == clkgen_pkg::SRC_INT |=> sys_src_active == clkgen_pkg::SRC_INT)
      else $error("internal source not selected");
   AST_BUS_CLOCK_DIVIDER_RST: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> bus_clock_divider == 2'h1)
      else $error("bus divider reset wrong");
   AST_EXT_REF_DIVIDER_RSVD: assert property (@(posedge clk) disable iff (!rst_n)
      (extra_div_by_32_mode && ext_ref_divider > 3'h5) |=> div_reserved)
      else $error("reserved divider not flagged");
   AST_EXT_REF_DIVIDER_FACT: assert property (@(posedge clk) disable iff (!rst_n)
      (pll_select || !range_high) |-> ext_ref_divider_factor == pow2(ext_ref_divider))
      else $error("divide factor wrong");
   AST_PLL_FACT: assert property (@(posedge clk) disable iff (!rst_n)
      (pll_select && ext_ref_divider == 3'h7) |-> ext_ref_divider_factor == 11'h080)
      else $error("pll divide factor wrong");
   AST_INT_STOP: assert property (@(posedge clk) disable iff (!rst_n)
      (in_stop && !int_ref_stop_keep) |=> !int_ref_enable)
      else $error("internal reference kept in stop");
   AST_EXT_STOP: assert property (@(posedge clk) disable iff (!rst_n)
      (in_stop && ext_ref_stop_keep && ext_ref_out_enable) |=> ext_ref_enable)
      else $error("external reference lost in stop");
   AST_LP: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_r == ST_LOW_POWER) |-> !loop_enable ##0 1'b1)
      else $error("loop on in low power bypass");
   AST_IROUT: assert property (@(posedge clk) disable iff (!rst_n)
      !int_ref_out_enable |=> !int_ref_clock_out)
      else $error("internal reference output active");
   AST_EROUT: assert property (@(posedge clk) disable iff (!rst_n)
      !ext_ref_out_enable |=> !ext_ref_clock_out)
      else $error("external reference output active");
   COV_LP: cover property (@(posedge clk) mode_r == ST_LOW_POWER);
   COV_STOP: cover property (@(posedge clk) mode_r == ST_STOP);
   COV_BUS: cover property (@(posedge clk) bus_clk_tick);
   COV_EXT: cover property (@(posedge clk) sys_src_active == clkgen_pkg::SRC_EXT);
endmodule

/* tb/tb.sv */
// self-checking bench for the clock generator control registers
`timescale 1ns/1ps
module tb;
   logic clk, rst_n, wr_en, rd_en, stop_req, pll_select, tk;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, rv;
   logic [1:0] sys_src_active;
   logic sys_clk_tick, bus_clk_tick, ext_ref_div_tick, int_ref_clock_out, ext_ref_clock_out;
   logic int_ref_enable, ext_ref_enable, loop_enable, osc_high_range, osc_high_gain;
   logic ext_source_osc_select, div_reserved;
   logic [15:0] c_bus, c_erd, c_iro, c_ero, s_bus, s_erd, s_iro, s_ero;
   int miscompares = 0;
   int checked = 0;
   clock_generator_control_regs clock_generator_control_regs_inst (.clk(clk), .rst_n(rst_n),
      .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .stop_req(stop_req),
      .pll_select(pll_select), .int_ref_tick(tk), .ext_ref_tick(tk), .loop_tick(tk),
      .rdata(rdata), .sys_src_active(sys_src_active), .sys_clk_tick(sys_clk_tick),
      .bus_clk_tick(bus_clk_tick), .ext_ref_div_tick(ext_ref_div_tick),
      .int_ref_clock_out(int_ref_clock_out), .ext_ref_clock_out(ext_ref_clock_out),
      .int_ref_enable(int_ref_enable), .ext_ref_enable(ext_ref_enable),
      .loop_enable(loop_enable), .osc_high_range(osc_high_range),
      .osc_high_gain(osc_high_gain), .ext_source_osc_select(ext_source_osc_select),
      .div_reserved(div_reserved));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // pulse counters for the divided outputs and the reference clock outputs
   initial {c_bus, c_erd, c_iro, c_ero} = 64'h0;
   always @(posedge clk) begin
      if (bus_clk_tick === 1'b1) c_bus <= c_bus + 16'h1;
      if (ext_ref_div_tick === 1'b1) c_erd <= c_erd + 16'h1;
      if (int_ref_clock_out === 1'b1) c_iro <= c_iro + 16'h1;
      if (ext_ref_clock_out === 1'b1) c_ero <= c_ero + 16'h1;
   end
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic run(input int n);
      @(negedge clk);
      {s_bus, s_erd, s_iro, s_ero} = {c_bus, c_erd, c_iro, c_ero};
      @(posedge clk);
      tk <= 1'b1;
      repeat (n) @(posedge clk);
      tk <= 1'b0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      {s_bus, s_erd, s_iro, s_ero} = {c_bus-s_bus, c_erd-s_erd, c_iro-s_iro, c_ero-s_ero};
   endtask
   function automatic logic [15:0] near(input logic [15:0] c, input logic [15:0] e);
      return {15'h0, (c + 16'h1 >= e) && (c <= e + 16'h1)};
   endfunction
   task automatic t_reset();
      rd(4'h0, rv);
      check("ctrl_one_rst", rv, 16'h04);
      rd(4'h1, rv);
      check("ctrl_two_rst", rv, 16'h40);
      check("src_rst", sys_src_active, 16'h0);
      rd(4'h2, rv);
      check("status_rst", rv, 16'h14);
      $display("test reset done");
   endtask
   task automatic t_src();
      for (int i = 0; i < 4; i++) begin
         wr(4'h0, {i[1:0], 6'h00});
         check("src", sys_src_active, (i == 3) ? 16'h0 : 16'(i));
      end
      $display("test source done");
   endtask
   task automatic t_bits();
      wr(4'h1, 8'h34);
      check("range", osc_high_range, 16'h1);
      check("gain", osc_high_gain, 16'h1);
      check("osc_sel", ext_source_osc_select, 16'h1);
      rd(4'h1, rv);
      check("ctrl_two_rd", rv, 16'h34);
      wr(4'h1, 8'h00);
      check("bits_off", {osc_high_range, osc_high_gain, ext_source_osc_select}, 16'h0);
      wr(4'h5, 8'hFF);
      rd(4'h5, rv);
      check("unmapped", rv, 16'h00);
      rd(4'h0, rv);
      check("ctrl_one_kept", rv, 16'hC0);
      $display("test bits done");
   endtask
   task automatic t_refdiv();
      pll_select <= 1'b1;
      wr(4'h0, 8'h10);
      run(64);
      check("pll_div4", near(s_erd, 16'd16), 16'h1);
      pll_select <= 1'b0;
      wr(4'h0, 8'h18);
      run(64);
      check("fll_low_div8", near(s_erd, 16'd8), 16'h1);
      wr(4'h1, 8'h60);
      wr(4'h0, 8'h00);
      run(64);
      check("fll_high_extra_div_by_32", near(s_erd, 16'd2), 16'h1);
      wr(4'h0, 8'h30);
      check("rsvd6", div_reserved, 16'h1);
      wr(4'h0, 8'h28);
      check("code5", div_reserved, 16'h0);
      pll_select <= 1'b1;
      wr(4'h0, 8'h30);
      check("pll6", div_reserved, 16'h0);
      pll_select <= 1'b0;
      $display("test ref divider done");
   endtask
   task automatic t_bus();
      wr(4'h0, 8'h44);
      for (int i = 0; i < 4; i++) begin
         wr(4'h1, {i[1:0], 6'h00});
         run(64);
         check("bus_div", near(s_bus, 16'd64 >> i), 16'h1);
      end
      $display("test bus divider done");
   endtask
   task automatic t_outen();
      wr(4'h0, 8'h46);
      wr(4'h1, 8'h02);
      run(32);
      check("iro_on", 16'(s_iro > 0), 16'h1);
      check("ero_on", 16'(s_ero > 0), 16'h1);
      wr(4'h0, 8'h44);
      wr(4'h1, 8'h00);
      run(32);
      check("iro_off", s_iro, 16'h0);
      check("ero_off", s_ero, 16'h0);
      $display("test output enables done");
   endtask
   task automatic stop_chk(input logic [7:0] one, input logic [7:0] two, input logic [1:0] e);
      wr(4'h0, one);
      wr(4'h1, two);
      stop_req <= 1'b1;
      repeat (6) @(posedge clk);
      #1 check("stop_en", {int_ref_enable, ext_ref_enable}, 16'(e));
      stop_req <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   task automatic t_stop();
      stop_chk(8'h45, 8'h00, 2'b10);
      stop_chk(8'h81, 8'h01, 2'b01);
      stop_chk(8'h82, 8'h02, 2'b00);
      wr(4'h0, 8'h44);
      wr(4'h1, 8'h08);
      check("lp_off", loop_enable, 16'h0);
      wr(4'h1, 8'h00);
      check("lp_on", loop_enable, 16'h1);
      $display("test stop and low power done");
   endtask
   task automatic results();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      {wr_en, rd_en, stop_req, pll_select, tk} = 5'h0;
      addr = 4'h0;
      wdata = 8'h00;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_src();
      t_bits();
      t_refdiv();
      t_bus();
      t_outen();
      t_stop();
      results();
   end
   initial begin
      #200us;
      miscompares++;
      results();
   end
endmodule
